/* File: common/vdc_pkg.sv */
// Constants for the blanking-interval data capture register bank.
// Assumes a host port that presents an 8-bit sub-address with a write strobe; reads are decoded from the sub-address alone.
package vdc_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_REQUEST = 8'h0A;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PROTECT = 8'h11;
  localparam logic [7:0] ADDR_CAP_LO = 8'h12;
  localparam logic [7:0] ADDR_CAP_HI = 8'h13;
  localparam logic [7:0] ADDR_EXT_LO = 8'h14;
  localparam logic [7:0] ADDR_EXT_HI = 8'h15;
  localparam logic [7:0] ADDR_BID_UP = 8'h16;
  localparam logic [7:0] ADDR_BID_LO = 8'h17;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int REQ_CAP_BIT = 0;
  localparam int REQ_EXT_BIT = 1;
  localparam int REQ_BID_BIT = 2;
  localparam int ST_CAP_BIT = 5;
  localparam int ST_EXT_BIT = 6;
  localparam int ST_BID_BIT = 7;
  // ----------------------------------------------------------------------
  // Line numbers and reset values
  // ----------------------------------------------------------------------
  localparam logic [9:0] LINE_CAP = 10'h015;
  localparam logic [9:0] LINE_EXT = 10'h11C;
  localparam logic [9:0] LINE_VBID_A = 10'h014;
  localparam logic [9:0] LINE_VBID_B = 10'h11B;
  localparam logic [9:0] LINE_WSS = 10'h017;
  localparam logic RST_DONE = 1'b1;
  localparam logic [7:0] RST_DATA = 8'h00;
endpackage : vdc_pkg

/* File: verilog/vdc_regs.sv */
// Capture and status registers for blanking-interval data and protection flags.
// Assumes the decoder core delivers decoded words with a strobe and line number.
module vdc_regs
  import vdc_pkg::*;
(
  input wire logic clk,               // Decoder core clock.
  input wire logic sys_rst,           // Synchronous reset, active high.
  input wire logic [7:0] reg_addr,    // Host sub-address.
  input wire logic reg_wr,            // Host write strobe.
  input wire logic [7:0] reg_wdata,   // Host write data.
  output logic [7:0] reg_rdata,       // Read data for reg_addr.
  input wire logic line_625,          // High for 625-line input.
  input wire logic [9:0] line_num,    // Current line number.
  input wire logic dec_valid,         // One-cycle decoded word strobe.
  input wire logic [15:0] dec_word,   // Decoded word of the line.
  input wire logic crc_ok,            // Cyclic check outcome for VBID.
  input wire logic [6:0] protect_in,  // Live protection detector flags.
  output logic [2:0] done_flags       // Done flags: blanking ID, extra, caption.
);
  import vdc_pkg::*;

  // ----------------------------------------------------------------------
  // Decode of host writes and line matches
  // ----------------------------------------------------------------------
  logic cap_q, ext_q, bid_q;
  logic cap_arm_q, ext_arm_q, bid_arm_q;
  logic [15:0] cap_word_q, ext_word_q;
  logic [7:0] bid_up_q, bid_lo_q, prot_q;
  wire req_wr = reg_wr && (reg_addr == ADDR_REQUEST);
  wire rq_cap = req_wr && reg_wdata[REQ_CAP_BIT];
  wire rq_ext = req_wr && reg_wdata[REQ_EXT_BIT];
  wire rq_bid = req_wr && reg_wdata[REQ_BID_BIT];
  wire is_cap = !line_625 && (line_num == LINE_CAP);
  wire is_ext = !line_625 && (line_num == LINE_EXT);
  wire is_vbid = !line_625 && (line_num == LINE_VBID_A || line_num == LINE_VBID_B);
  wire is_wss = line_625 && (line_num == LINE_WSS);
  // A fresh request ignores data in its own write cycle so it waits for the next line.
  wire hit_cap = dec_valid && is_cap && cap_arm_q && !rq_cap;
  wire hit_ext = dec_valid && is_ext && ext_arm_q && !rq_ext;
  wire hit_vbid = dec_valid && is_vbid && bid_arm_q && !rq_bid;
  wire hit_wss = dec_valid && is_wss && bid_arm_q && !rq_bid;
  // VBID bit 1 is the first received and lands in bit 5 of the upper byte.
  wire [13:0] vbid_bits = {crc_ok, dec_word[12:0]};
  // ----------------------------------------------------------------------
  // Arming, done flags and capture registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap_arm_q <= 1'b0;
      ext_arm_q <= 1'b0;
      bid_arm_q <= 1'b0;
      cap_q <= RST_DONE;
      ext_q <= RST_DONE;
      bid_q <= RST_DONE;
      cap_word_q <= {RST_DATA, RST_DATA};
      ext_word_q <= {RST_DATA, RST_DATA};
      bid_up_q <= RST_DATA;
      bid_lo_q <= RST_DATA;
      prot_q <= RST_DATA;
    end else begin
      cap_arm_q <= rq_cap || (cap_arm_q && !hit_cap);
      ext_arm_q <= rq_ext || (ext_arm_q && !hit_ext);
      bid_arm_q <= rq_bid || (bid_arm_q && !(hit_vbid || hit_wss));
      cap_q <= hit_cap || (cap_q && !rq_cap);
      ext_q <= hit_ext || (ext_q && !rq_ext);
      bid_q <= hit_vbid || hit_wss || (bid_q && !rq_bid);
      if (hit_cap) cap_word_q <= dec_word;
      if (hit_ext) ext_word_q <= dec_word;
      if (hit_vbid) begin
        bid_up_q <= {2'b00, vbid_bits[0], vbid_bits[1], vbid_bits[2], vbid_bits[3], vbid_bits[4],
                     vbid_bits[5]};
        bid_lo_q <= {vbid_bits[6], vbid_bits[7], vbid_bits[8], vbid_bits[9], vbid_bits[10],
                     vbid_bits[11], vbid_bits[12], vbid_bits[13]};
      end else if (hit_wss) begin
        bid_up_q <= {2'b00, dec_word[13:8]};
        bid_lo_q <= dec_word[7:0];
      end
      // Stripe type only means something while a stripe is seen.
      prot_q <= {1'b0, protect_in[6:3], protect_in[2] & protect_in[1], protect_in[1:0]};
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [7:0] status_byte = {bid_q, ext_q, cap_q, 5'b0_0000};
  always_comb begin
    unique case (reg_addr)
      ADDR_STATUS: reg_rdata = status_byte;
      ADDR_PROTECT: reg_rdata = prot_q;
      ADDR_CAP_LO: reg_rdata = cap_word_q[7:0];
      ADDR_CAP_HI: reg_rdata = cap_word_q[15:8];
      ADDR_EXT_LO: reg_rdata = ext_word_q[7:0];
      ADDR_EXT_HI: reg_rdata = ext_word_q[15:8];
      ADDR_BID_UP: reg_rdata = bid_up_q;
      ADDR_BID_LO: reg_rdata = bid_lo_q;
      default: reg_rdata = RST_DATA;
    endcase
  end
  assign done_flags = {bid_q, ext_q, cap_q};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_cap_clear;
    @(posedge clk) disable iff (sys_rst) rq_cap |=> !cap_q;
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("caption done not cleared");
  property p_cap_set;
    @(posedge clk) disable iff (sys_rst) hit_cap |=> cap_q && cap_word_q == $past(dec_word);
  endproperty
  a_cap_set: assert property (p_cap_set) else $error("caption capture failed");
  property p_ext_clear;
    @(posedge clk) disable iff (sys_rst) rq_ext |=> !ext_q;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("extra done not cleared");
  property p_ext_set;
    @(posedge clk) disable iff (sys_rst) hit_ext |=> ext_q && ext_word_q == $past(dec_word);
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("extra capture failed");
  property p_ext_hold;
    @(posedge clk) disable iff (sys_rst) !hit_ext |=> $stable(ext_word_q);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("extra data changed");
  property p_bid_clear;
    @(posedge clk) disable iff (sys_rst) rq_bid |=> !bid_q;
  endproperty
  a_bid_clear: assert property (p_bid_clear) else $error("blanking done not cleared");
  property p_wss_map;
    @(posedge clk) disable iff (sys_rst) hit_wss |=> bid_q && bid_lo_q == $past(dec_word[7:0]);
  endproperty
  a_wss_map: assert property (p_wss_map) else $error("wss capture failed");
  property p_vbid_625;
    @(posedge clk) disable iff (sys_rst) line_625 && !hit_wss |=> $stable(bid_lo_q);
  endproperty
  a_vbid_625: assert property (p_vbid_625) else $error("vbid taken on 625 lines");
  property p_prot_rsv;
    @(posedge clk) disable iff (sys_rst) !prot_q[1] |-> !prot_q[2] && !prot_q[7];
  endproperty
  a_prot_rsv: assert property (p_prot_rsv) else $error("stripe type without stripe");
endmodule : vdc_regs

/* File: sim/vdc_host_model.sv */
// Host model for the capture register bank: writes requests and reads results on the register port.
// Assumes the bench clock; it changes its signals only on the falling edge.
module vdc_host_model (
  input wire logic clk,             // Core clock.
  output logic [7:0] reg_addr,      // Sub-address.
  output logic reg_wr,              // Write strobe.
  output logic [7:0] reg_wdata,     // Write data.
  input wire logic [7:0] reg_rdata  // Read data.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // The data bus is inverted once the strobe drops, so a stale value is never mistaken for a write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // The read path is combinational, so the data is taken one full period later, at the next falling edge, clear of the rising edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : vdc_host_model

/* File: sim/tb_vbi_data_capture_regs.sv */
// Self-checking bench for the capture register bank.
// Assumes the host model above; decoded words are injected directly with their line number.
module tb_vbi_data_capture_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import vdc_pkg::*;
  typedef struct packed {
    logic [7:0] req; logic l625; logic [9:0] line; logic [15:0] word; logic crc;
    logic [7:0] alo; logic [15:0] exp; logic [2:0] done;
  } vdc_row_s;
  // Expected pair: exp[7:0] at alo, exp[15:8] at alo plus one; refused rows keep the older contents.
  localparam vdc_row_s ROWS [10] = '{
    '{8'h01, 1'b0, LINE_CAP, 16'hA55A, 1'b0, ADDR_CAP_LO, 16'hA55A, 3'h7},
    '{8'h02, 1'b0, LINE_EXT, 16'h1234, 1'b0, ADDR_EXT_LO, 16'h1234, 3'h7},
    '{8'h04, 1'b0, LINE_VBID_A, 16'h0ABC, 1'b1, ADDR_BID_UP, 16'h550F, 3'h7},
    '{8'h04, 1'b0, LINE_VBID_B, 16'h1FFF, 1'b0, ADDR_BID_UP, 16'hFE3F, 3'h7},
    '{8'h04, 1'b1, LINE_WSS, 16'hED96, 1'b0, ADDR_BID_UP, 16'h962D, 3'h7},
    '{8'h04, 1'b1, LINE_VBID_A, 16'h1234, 1'b1, ADDR_BID_UP, 16'h962D, 3'h3},
    '{8'h01, 1'b0, LINE_EXT, 16'h0000, 1'b0, ADDR_CAP_LO, 16'hA55A, 3'h2},
    '{8'h04, 1'b0, LINE_WSS, 16'h0000, 1'b0, ADDR_BID_UP, 16'h962D, 3'h2},
    '{8'h02, 1'b0, LINE_CAP, 16'hFFFF, 1'b0, ADDR_EXT_LO, 16'h1234, 3'h1},
    '{8'h01, 1'b0, LINE_CAP, 16'h0001, 1'b0, ADDR_CAP_LO, 16'h0001, 3'h1}};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, line_625 = 1'b0, dec_valid = 1'b0, crc_ok = 1'b0;
  logic [9:0] line_num = 10'h000;
  logic [15:0] dec_word = 16'h0000;
  logic [6:0] protect_in = 7'h00;
  logic [6:0] pv;
  logic [2:0] done_flags;
  int fail_count = 0;
  int checks = 0;
  always #25 clk = ~clk;
  vdc_host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  vdc_regs dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .line_625(line_625), .line_num(line_num), .dec_valid(dec_valid),
    .dec_word(dec_word), .crc_ok(crc_ok), .protect_in(protect_in), .done_flags(done_flags));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk3
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
  endtask : do_reset
  // The strobe lasts one cycle; the trailing wait lets the registered done flag settle.
  task automatic decode(input logic m, input logic [9:0] ln, input logic [15:0] w, input logic c);
    @(negedge clk);
    line_625 = m;
    line_num = ln;
    dec_word = w;
    crc_ok = c;
    dec_valid = 1'b1;
    @(negedge clk);
    dec_valid = 1'b0;
    dec_word = ~w;
    crc_ok = ~c;
    @(negedge clk);
  endtask : decode
  task automatic print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    chk3(done_flags, 3'h7);
    for (int i = 0; i < 10; i++) begin
      host_u.wr(ADDR_REQUEST, ROWS[i].req);
      @(negedge clk);
      chk3(done_flags & ROWS[i].req[2:0], 3'h0);
      decode(ROWS[i].l625, ROWS[i].line, ROWS[i].word, ROWS[i].crc);
      chk3(done_flags, ROWS[i].done);
      host_u.rd(ADDR_STATUS, d);
      chk8(d, {ROWS[i].done, 5'h00});
      host_u.rd(ROWS[i].alo, d);
      chk8(d, ROWS[i].exp[7:0]);
      host_u.rd(ROWS[i].alo + 8'h01, d);
      chk8(d, ROWS[i].exp[15:8]);
    end
    foreach (ROWS[i]) begin
      pv = 7'h55 ^ 7'(i * 8'h13);
      protect_in = pv;
      repeat (2) @(negedge clk);
      host_u.wr(ADDR_PROTECT, 8'hFF);
      host_u.rd(ADDR_PROTECT, d);
      chk8(d, {1'b0, pv[6:3], pv[2] & pv[1], pv[1:0]});
    end
    host_u.rd(8'h20, d);
    chk8(d, 8'h00);
    fork
      host_u.wr(ADDR_REQUEST, 8'h01);
      decode(1'b0, LINE_CAP, 16'hBEEF, 1'b0);
    join
    chk3(done_flags, 3'h0);
    host_u.rd(ADDR_CAP_HI, d);
    chk8(d, 8'h00);
    do_reset();
    chk3(done_flags, 3'h7);
    host_u.rd(ADDR_BID_LO, d);
    chk8(d, RST_DATA);
    print_verdict();
  end
  initial begin
    #(50 * 4000);
    fail_count++;
    print_verdict();
  end
endmodule : tb_vbi_data_capture_regs
